//--- design/hall_quadrature_index_encoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "hall_encoder_defs.svh"

module hall_quadrature_index_encoder
    import hall_encoder_pkg::*;
#(
    parameter int PWRUP_CYC = `PWRUP_CYC,
    parameter int STEPS     = `STEPS_PER_PAIR,
    parameter int HYST      = `HYST_STEPS
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Interpolator front end
    input  wire logic [7:0] raw_pos,
    input  wire logic       amp_ok,
    input  wire logic       interp_locked,
    // Incremental outputs
    output logic            quad_a,
    output logic            quad_b,
    output logic            index_out
);

    localparam int PW = $clog2(PWRUP_CYC + 1);
    localparam logic [PW-1:0] PWRUP_LAST = PW'(PWRUP_CYC);

    enc_state_t    st_q;
    enc_state_t    st_d;
    logic [PW-1:0] pwr_cnt_q;
    logic          pwr_done_q;
    logic [7:0]    pos_q;
    logic          fwd_q;
    quad_out_t     out_q;
    quad_out_t     out_d;

    // The start-up window runs once from reset.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pwr_cnt_q <= '0;
        else if (pwr_cnt_q != PWRUP_LAST)
            pwr_cnt_q <= pwr_cnt_q + PW'(1);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pwr_done_q <= 1'b0;
        else if (pwr_cnt_q == PWRUP_LAST)
            pwr_done_q <= 1'b1;
    end

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_WAIT:
            begin
                if (pwr_done_q && amp_ok && interp_locked)
                    st_d = ST_RUN;
            end
            ST_RUN:
            begin
                if (!amp_ok)
                    st_d = ST_LOWF;
                else if (!interp_locked)
                    st_d = ST_WAIT;
            end
            ST_LOWF:
            begin
                if (amp_ok && interp_locked)
                    st_d = ST_RUN;
            end
            default:
                st_d = ST_WAIT;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            st_q <= ST_WAIT;
        else
            st_q <= st_d;
    end

    // Outside normal running the tracker snaps to the raw position, so no burst follows.
    step_tracker #(
        .STEPS (STEPS),
        .HYST  (HYST)
    ) u_tracker (
        .sys_clk (sys_clk),
        .rst     (rst),
        .load    (st_q != ST_RUN),
        .raw_pos (raw_pos),
        .pos_q   (pos_q),
        .fwd_q   (fwd_q)
    );

    // Phase within a cycle of four steps: 0 gives 11, 1 gives 01, 2 gives 00, 3 gives 10.
    always_comb
    begin
        out_d = '0;
        case (st_q)
            ST_RUN:
            begin
                out_d.quad_a = ~(pos_q[1] ^ pos_q[0]);
                out_d.quad_b = ~pos_q[1];
                out_d.index  = (pos_q == `INDEX_POS);
            end
            ST_LOWF:
            begin
                out_d.index = 1'b1;
            end
            ST_WAIT:
            begin
                out_d = '0;
            end
            default:
                out_d = '0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            out_q <= '0;
        else
            out_q <= out_d;
    end

    assign quad_a    = out_q.quad_a;
    assign quad_b    = out_q.quad_b;
    assign index_out = out_q.index;

    sequence s_run2;
        (st_q == ST_RUN) ##1 (st_q == ST_RUN);
    endsequence

    property p_gray;
        @(posedge sys_clk) disable iff (rst)
        s_run2 |=> !($changed(quad_a) && $changed(quad_b));
    endproperty
    a_gray: assert property (p_gray) else $error("both quadrature outputs toggled");

    property p_index_zero;
        @(posedge sys_clk) disable iff (rst)
        (st_q == ST_RUN) |=> (index_out == ($past(pos_q) == 8'h00));
    endproperty
    a_index_zero: assert property (p_index_zero) else $error("index not at zero");

    property p_index_ab;
        @(posedge sys_clk) disable iff (rst)
        (st_q == ST_RUN) |=> (!index_out || (quad_a && quad_b));
    endproperty
    a_index_ab: assert property (p_index_ab) else $error("index without A and B high");

    property p_lowf;
        @(posedge sys_clk) disable iff (rst)
        (st_q == ST_LOWF) |=> (index_out && !quad_a && !quad_b);
    endproperty
    a_lowf: assert property (p_lowf) else $error("low field code wrong");

    property p_wait_quiet;
        @(posedge sys_clk) disable iff (rst)
        (st_q == ST_WAIT) |=> (!index_out && !quad_a && !quad_b);
    endproperty
    a_wait_quiet: assert property (p_wait_quiet) else $error("outputs active before lock");

    property p_no_early_run;
        @(posedge sys_clk) disable iff (rst)
        !pwr_done_q |-> (st_q == ST_WAIT);
    endproperty
    a_no_early_run: assert property (p_no_early_run) else $error("running before start-up");

    property p_cw_lead;
        @(posedge sys_clk) disable iff (rst)
        (s_run2 ##1 ($rose(quad_a) && $past(fwd_q))) |-> !quad_b;
    endproperty
    a_cw_lead: assert property (p_cw_lead) else $error("A does not lead B forward");

    property p_ccw_lead;
        @(posedge sys_clk) disable iff (rst)
        (s_run2 ##1 ($rose(quad_b) && !$past(fwd_q))) |-> !quad_a;
    endproperty
    a_ccw_lead: assert property (p_ccw_lead) else $error("B does not lead A backward");

    property p_wait_hold;
        @(posedge sys_clk) disable iff (rst)
        (st_q == ST_WAIT && !(pwr_done_q && amp_ok && interp_locked)) |=> (st_q == ST_WAIT);
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("start-up wait left too early");

    property p_lowf_entry;
        @(posedge sys_clk) disable iff (rst)
        (st_q == ST_RUN && !amp_ok) |=> (st_q == ST_LOWF);
    endproperty
    a_lowf_entry: assert property (p_lowf_entry) else $error("weak field not flagged");

    property p_index_leaves;
        @(posedge sys_clk) disable iff (rst)
        (s_run2 ##1 (index_out && pos_q != 8'h00 && st_q == ST_RUN)) |=> !index_out;
    endproperty
    a_index_leaves: assert property (p_index_leaves) else $error("index stays high off zero");

endmodule // hall_quadrature_index_encoder

`default_nettype wire

//--- design/hall_encoder_defs.svh
`ifndef HALL_ENCODER_DEFS_SVH
`define HALL_ENCODER_DEFS_SVH

// Interpolated positions per pole pair and quadrature cycles per pole pair.
`define STEPS_PER_PAIR   160
`define QUAD_PER_PAIR    40
// Hysteresis in steps before the step direction may reverse.
`define HYST_STEPS       1
// Position of the index pulse within a pole pair.
`define INDEX_POS        8'h00
// Clock rate, start-up time limit and propagation limit.
`define CLK_MHZ          40
`define PWRUP_US         500
`define PROP_US          20
`define PWRUP_CYC        (`PWRUP_US * `CLK_MHZ)
`define PROP_CYC         (`PROP_US * `CLK_MHZ)

`endif

//--- design/hall_encoder_pkg.sv
`default_nettype none

package hall_encoder_pkg;

    typedef struct packed {
        logic quad_a;
        logic quad_b;
        logic index;
    } quad_out_t;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_RUN  = 3'b010,
        ST_LOWF = 3'b100
    } enc_state_t;

endpackage

`default_nettype wire

//--- design/step_tracker.sv
`timescale 1ns/1ps
`default_nettype none
`include "hall_encoder_defs.svh"

module step_tracker #(
    parameter int STEPS = `STEPS_PER_PAIR,
    parameter int HYST  = `HYST_STEPS
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Control
    input  wire logic       load,
    input  wire logic [7:0] raw_pos,
    // Tracked position
    output logic      [7:0] pos_q,
    output logic            fwd_q
);

    localparam logic [8:0] STEPS_W = 9'(STEPS);
    localparam logic [8:0] HALF_W  = 9'(STEPS / 2);
    localparam logic [8:0] HYST_W  = 9'(HYST);
    localparam logic [7:0] LAST_W  = 8'(STEPS - 1);

    logic [8:0] diff;
    logic       step_up;
    logic       step_dn;

    // Distance from tracked to raw position, forward around the pole pair.
    always_comb
    begin
        if (raw_pos >= pos_q)
            diff = {1'b0, raw_pos} - {1'b0, pos_q};
        else
            diff = {1'b0, raw_pos} + STEPS_W - {1'b0, pos_q};
    end

    // Continuing in the same direction needs one step; reversing needs more than the hysteresis.
    assign step_up = (diff != 9'h000) && (diff < HALF_W) && (fwd_q || diff > HYST_W);
    assign step_dn = (diff >= HALF_W) && (!fwd_q || (STEPS_W - diff) > HYST_W);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pos_q <= 8'h00;
        else if (load)
            pos_q <= raw_pos;
        else if (step_up)
            pos_q <= (pos_q == LAST_W) ? 8'h00 : pos_q + 8'h01;
        else if (step_dn)
            pos_q <= (pos_q == 8'h00) ? LAST_W : pos_q - 8'h01;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            fwd_q <= 1'b1;
        else if (!load && step_up)
            fwd_q <= 1'b1;
        else if (!load && step_dn)
            fwd_q <= 1'b0;
    end

    property p_hyst_hold;
        @(posedge sys_clk) disable iff (rst)
        (!load && fwd_q && diff >= HALF_W && (STEPS_W - diff) <= HYST_W) |=> $stable(pos_q);
    endproperty
    a_hyst_hold: assert property (p_hyst_hold) else $error("reversal inside hysteresis");

    property p_follow;
        @(posedge sys_clk) disable iff (rst)
        (!load && fwd_q && diff == 9'h001) |=> (pos_q == $past(raw_pos));
    endproperty
    a_follow: assert property (p_follow) else $error("one step ahead not followed");

endmodule // step_tracker

`default_nettype wire

//--- bench/quad_counter.sv
`timescale 1ns/1ps
`default_nettype none

module quad_counter (
    // Clock, reset and clear
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clr,
    // Encoder lines
    input  wire logic        quad_a,
    input  wire logic        quad_b,
    input  wire logic        index_out,
    // Tallies
    output logic      [31:0] count,
    output logic      [31:0] index_cnt,
    output logic      [31:0] bad_cnt
);
    logic [1:0] ab_q;
    logic       idx_q;
    logic [1:0] delta;

    // The phase of the line pair rises by one for each forward step.
    assign delta = {~quad_b, quad_a ^ quad_b} - {~ab_q[0], ab_q[1] ^ ab_q[0]};

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            count     <= 32'h0;
            index_cnt <= 32'h0;
            bad_cnt   <= 32'h0;
            ab_q      <= 2'h0;
            idx_q     <= 1'b0;
        end
        else if (clr)
        begin
            count     <= 32'h0;
            index_cnt <= 32'h0;
            bad_cnt   <= 32'h0;
            ab_q      <= {quad_a, quad_b};
            idx_q     <= index_out;
        end
        else
        begin
            ab_q  <= {quad_a, quad_b};
            idx_q <= index_out;
            if (delta == 2'h1)
                count <= count + 32'h1;
            else if (delta == 2'h3)
                count <= count - 32'h1;
            else if (delta == 2'h2)
                bad_cnt <= bad_cnt + 32'h1;
            if (index_out && !idx_q && quad_a && quad_b)
                index_cnt <= index_cnt + 32'h1;
        end
    end
endmodule // quad_counter

`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import hall_encoder_pkg::*;
    localparam int PWRUP = 16;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  raw_pos = 8'h00;
    logic        amp_ok = 1'b1;
    logic        interp_locked = 1'b1;
    logic        clr = 1'b0;
    logic        quad_a;
    logic        quad_b;
    logic        index_out;
    logic [31:0] count;
    logic [31:0] index_cnt;
    logic [31:0] bad_cnt;
    int          errors = 0;
    int          compares = 0;

    always #12.5 sys_clk = ~sys_clk;

    hall_quadrature_index_encoder #(.PWRUP_CYC(PWRUP)) i_hall_quadrature_index_encoder (
        .sys_clk(sys_clk), .rst(rst), .raw_pos(raw_pos), .amp_ok(amp_ok),
        .interp_locked(interp_locked), .quad_a(quad_a), .quad_b(quad_b),
        .index_out(index_out));

    quad_counter i_quad_counter (
        .sys_clk(sys_clk), .rst(rst), .clr(clr), .quad_a(quad_a), .quad_b(quad_b),
        .index_out(index_out), .count(count), .index_cnt(index_cnt), .bad_cnt(bad_cnt));

    task automatic stop_test;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    function automatic quad_out_t at_pos(input int p);
        quad_out_t o;
        o.quad_a = (p % 4 == 0) || (p % 4 == 3);
        o.quad_b = (p % 4 < 2);
        o.index  = (p == 0);
        return o;
    endfunction

    task automatic wait_out(input quad_out_t exp);
        int n = 0;
        while ({quad_a, quad_b, index_out} !== exp && n < 40)
        begin
            cyc(1);
            n++;
        end
        if ({quad_a, quad_b, index_out} !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t output wait timed out", $time);
            stop_test;
        end
    endtask

    task automatic t_startup;
        cyc(6);
        rst = 1'b0;
        cyc(PWRUP - 2);
        chk({quad_a, quad_b, index_out}, 3'h0);
        wait_out(at_pos(0));
        chk({quad_a, quad_b, index_out}, at_pos(0));
    endtask

    task automatic t_forward;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        for (int p = 1; p <= 160; p++)
        begin
            raw_pos = 8'(p % 160);
            cyc(2);
            chk({quad_a, quad_b, index_out}, at_pos(p % 160));
        end
        cyc(1);
        chk(count, 32'ha0);
        chk(index_cnt, 32'h1);
        chk(bad_cnt, 32'h0);
    endtask

    task automatic t_reverse;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        raw_pos = 8'h9f;
        cyc(3);
        chk({quad_a, quad_b, index_out}, at_pos(0));
        for (int p = 158; p >= 0; p--)
        begin
            raw_pos = 8'(p);
            cyc(3);
            chk({quad_a, quad_b, index_out}, at_pos(p));
        end
        chk(count, 32'hffffff60);
        chk(index_cnt, 32'h1);
        chk(bad_cnt, 32'h0);
    endtask

    task automatic t_faults;
        amp_ok = 1'b0;
        cyc(3);
        chk({quad_a, quad_b, index_out}, 3'h1);
        amp_ok = 1'b1;
        cyc(3);
        chk({quad_a, quad_b, index_out}, at_pos(0));
        interp_locked = 1'b0;
        cyc(3);
        chk({quad_a, quad_b, index_out}, 3'h0);
        raw_pos = 8'h05;
        interp_locked = 1'b1;
        wait_out(at_pos(5));
        chk({quad_a, quad_b, index_out}, at_pos(5));
    endtask

    initial
    begin
        t_startup;
        t_forward;
        t_reverse;
        t_faults;
        stop_test;
    end
endmodule // tb

`default_nettype wire
